/* design/nfc_core.sv */
// NCO core: parallel and serial control, phase accumulator, sine and DAC code.
// Notes on behaviour
// - Increment is center plus offset plus serial term, kept to 48 bits.
// - Center and serial terms zeroed by register bits, offset by its pin.
// - Serial words of 8 to 40 bits sit with their MSB at bit 47.
// - Accumulator adds increment each clock; top 24 bits address the sine.
// - The 16-bit sine amplitude is rounded to a 14-bit DAC code.
// - Phase bit 47 is the top sine address and weighs 180 degrees.
// - Two phase-select pins add 0, 90, 180 or 270 degrees before lookup.
// - Host writes bytes via data, address, strobe, low enable; no readback.
// - Writes fill master registers; update copies center, offset and term control to slaves at once.
// - With update held active, output follows a write after fourteen clocks.
// - Update after writing shows the new frequency fourteen clocks later.
// - Offset-enable toggle adds or removes the offset fourteen clocks later.
// - Serial word shifts on its own clock, is held, then synchronised.
// - A serial transfer of N bytes takes 8N plus three serial clocks.
// - Output reflects a serial word twelve clocks after its slave update.
// - Center and offset words are reachable only from the parallel port.
// - Serial term enabled after reset; clearing bit 6 of register 13 disables it.
// - Any write to address 15 acts as an update.
// - Reset gives center fclk/4, offset disabled, serial term enabled.
// - Writes are ignored until one clock edge after reset release.
// - Phase, offset-enable and update pins are synchronised before use.
`timescale 1ns/1ps
module nfc_core #(
  parameter int Delay = nfc_pkg::PipeDelay
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Parallel control port.
  input wire logic wrStrobe,
  input wire logic writeEnN,
  input wire logic [3:0] ctlAddr,
  input wire logic [7:0] ctlData,
  input wire logic updateN,
  // Modulation pins.
  input wire logic phaseSelectLsb,
  input wire logic phaseSelectMsb,
  input wire logic offsetTermEnablePin,
  // Serial control port.
  input wire logic sclk,
  input wire logic serData,
  input wire logic serSync,
  // DAC code, offset binary.
  output logic [nfc_pkg::DacW-1:0] dacCode
);
  localparam int PinW = 18;

  initial begin
    if (Delay != nfc_pkg::PipeDelay) begin
      $error("nfc_core pipeline depth must match the output latency");
    end
  end

  // Pin synchronisers; the serial toggle has its own pair.
  logic [PinW-1:0] s1Q, s2Q;
  logic [2:0] togQ;
  logic [PinW-1:0] pinVec;
  logic [nfc_pkg::SerMaxW-1:0] holdWord;
  logic loadToggle;
  logic wrS, weNS, updNS, ofsPinS;
  logic [3:0] addrS;
  logic [7:0] dataS;
  logic [1:0] phSelS;

  always_comb begin
    pinVec = {wrStrobe, writeEnN, ctlAddr, ctlData, updateN,
              offsetTermEnablePin, phaseSelectMsb, phaseSelectLsb};
    {wrS, weNS, addrS, dataS, updNS, ofsPinS, phSelS} = s2Q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Idle pin levels, so no phase step or offset leaks out of reset.
      s1Q <= 18'h1_0008;
      s2Q <= 18'h1_0008;
      togQ <= 3'h0;
    end else begin
      s1Q <= pinVec;
      s2Q <= s1Q;
      togQ <= {togQ[1:0], loadToggle};
    end
  end

  // Control registers, master and slave.
  logic readyQ, readyD, wrPrevQ;
  logic [47:0] cenMQ, cenMD, ofsMQ, ofsMD, cenSQ, cenSD, ofsSQ, ofsSD;
  logic [7:0] cfgQ, cfgD, termMQ, termMD, termSQ, termSD, initQ, initD;
  logic [47:0] serSlaveQ, serSlaveD, serTermQ;
  logic ofsEnQ;
  logic [1:0] phSelQ;
  logic wrRise, loadSlave, serArrive;

  nfc_serial_port #(
    .MaxBytes(nfc_pkg::SerMaxBytes)
  ) u_serial (
    .sclk(sclk),
    .reset_n(reset_n),
    .serData(serData),
    .serSync(serSync),
    .byteCount(cfgQ[nfc_pkg::SerLenLsb +: nfc_pkg::SerLenW]),
    .holdWord(holdWord),
    .loadToggle(loadToggle)
  );

  always_comb begin
    wrRise = wrS & ~wrPrevQ & ~weNS & readyQ;
    readyD = 1'b1;
    cenMD = cenMQ;
    ofsMD = ofsMQ;
    cfgD = cfgQ;
    termMD = termMQ;
    initD = initQ;
    if (wrRise) begin
      for (int i = 0; i < nfc_pkg::FreqBytes; i++) begin
        if (addrS == 4'(nfc_pkg::AddrCenter0 + i)) begin
          cenMD[8*i +: 8] = dataS;
        end
        if (addrS == 4'(nfc_pkg::AddrOffset0 + i)) begin
          ofsMD[8*i +: 8] = dataS;
        end
      end
      if (addrS == nfc_pkg::AddrSerialCfg) begin
        cfgD = dataS;
      end
      if (addrS == nfc_pkg::AddrTermCtl) begin
        termMD = dataS;
      end
      if (addrS == nfc_pkg::AddrInitSet) begin
        initD = dataS;
      end
    end
    // A held update passes a write straight through in the same cycle.
    loadSlave = ~updNS | (wrRise & (addrS == nfc_pkg::AddrUpdate));
    cenSD = loadSlave ? cenMD : cenSQ;
    ofsSD = loadSlave ? ofsMD : ofsSQ;
    termSD = loadSlave ? termMD : termSQ;
    serArrive = togQ[2] ^ togQ[1];
    serSlaveD = serArrive ? {holdWord, 8'h00} : serSlaveQ;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readyQ <= 1'b0;
      wrPrevQ <= 1'b1;
      cenMQ <= nfc_pkg::CenterReset;
      ofsMQ <= nfc_pkg::OffsetReset;
      cenSQ <= nfc_pkg::CenterReset;
      ofsSQ <= nfc_pkg::OffsetReset;
      cfgQ <= nfc_pkg::SerialCfgReset;
      termMQ <= nfc_pkg::TermCtlReset;
      termSQ <= nfc_pkg::TermCtlReset;
      initQ <= nfc_pkg::InitSetReset;
      serSlaveQ <= 48'h0000_0000_0000;
      serTermQ <= 48'h0000_0000_0000;
      ofsEnQ <= 1'b0;
      phSelQ <= 2'h0;
    end else begin
      readyQ <= readyD;
      wrPrevQ <= wrS;
      cenMQ <= cenMD;
      ofsMQ <= ofsMD;
      cenSQ <= cenSD;
      ofsSQ <= ofsSD;
      cfgQ <= cfgD;
      termMQ <= termMD;
      termSQ <= termSD;
      initQ <= initD;
      serSlaveQ <= serSlaveD;
      serTermQ <= serSlaveQ;
      ofsEnQ <= ofsPinS;
      phSelQ <= phSelS;
    end
  end

  // The sine is a parabolic fit; spurs are traded for zero table area.
  logic [47:0] sumQ, sumD, accQ, accD;
  logic [47:0] dlyQ [Delay];
  logic [47:0] dlyD [Delay];
  logic [nfc_pkg::PhaseW-1:0] phaseQ, phaseD;
  logic signed [nfc_pkg::SineW-1:0] sineQ, sineD;
  logic [nfc_pkg::DacW-1:0] dacQ, dacD;
  logic [45:0] prod;
  logic [16:0] mag;
  logic signed [16:0] rnd;
  logic signed [14:0] code;

  always_comb begin
    sumD = (termSQ[nfc_pkg::TermCenterBit] ? cenSQ : 48'h0)
         + (ofsEnQ ? ofsSQ : 48'h0)
         + (termSQ[nfc_pkg::TermSerialBit] ? serTermQ : 48'h0);
    dlyD[0] = sumQ;
    for (int i = 1; i < Delay; i++) begin
      dlyD[i] = dlyQ[i-1];
    end
    accD = accQ + dlyQ[Delay-1];
    phaseD = accQ[47 -: nfc_pkg::PhaseW]
           + {phSelQ, 22'h00_0000};
    // Bit 23 of the address selects the negative half cycle; the parabola
    // spans the whole half, so its peak falls on the 90 degree point.
    prod = {23'h00_0000, phaseQ[22:0]}
         * {22'h0, 24'h80_0000 - {1'b0, phaseQ[22:0]}};
    mag = prod[45:29];
    if (mag > 17'h0_7FFF) begin
      mag = 17'h0_7FFF;
    end
    sineD = phaseQ[23] ? -16'(mag) : 16'(mag);
    rnd = 17'(sineQ) + 17'sh0_0002;
    code = 15'(rnd >>> 2);
    if (code > 15'sh1FFF) begin
      code = 15'sh1FFF;
    end
    dacD = {~code[13], code[12:0]};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sumQ <= 48'h0000_0000_0000;
      for (int i = 0; i < Delay; i++) begin
        dlyQ[i] <= 48'h0000_0000_0000;
      end
      accQ <= 48'h0000_0000_0000;
      phaseQ <= 24'h00_0000;
      sineQ <= 16'sh0000;
      dacQ <= 14'h2000;
    end else begin
      sumQ <= sumD;
      for (int i = 0; i < Delay; i++) begin
        dlyQ[i] <= dlyD[i];
      end
      accQ <= accD;
      phaseQ <= phaseD;
      sineQ <= sineD;
      dacQ <= dacD;
    end
  end

  assign dacCode = dacQ;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_sum_modulo: assert property (
    termSQ[nfc_pkg::TermCenterBit] && termSQ[nfc_pkg::TermSerialBit] && ofsEnQ
    |=> sumQ == 48'($past(cenSQ) + $past(ofsSQ) + $past(serTermQ)))
    else $error("frequency sum is not the 48-bit sum of the terms");
  a_terms_zero: assert property (
    !termSQ[nfc_pkg::TermCenterBit] && !termSQ[nfc_pkg::TermSerialBit]
    && !ofsEnQ |=> sumQ == 48'h0)
    else $error("disabled terms still reach the sum");
  a_slave_copy: assert property (
    !updNS |=> cenSQ == cenMQ && ofsSQ == ofsMQ && termSQ == termMQ)
    else $error("held update did not copy the masters");
  a_reg15_update: assert property (
    wrRise && addrS == nfc_pkg::AddrUpdate |=> cenSQ == cenMQ)
    else $error("write to address 15 did not update");
  a_write_blocked: assert property (
    !readyQ |=> $stable(cenMQ) && $stable(ofsMQ) && $stable(termMQ))
    else $error("write accepted before first edge after reset");
  a_parallel_only: assert property (
    !wrRise |=> $stable(cenMQ) && $stable(ofsMQ))
    else $error("center or offset master changed without a write");
  a_accum_step: assert property (
    ##1 accQ == 48'($past(accQ) + $past(dlyQ[Delay-1])))
    else $error("accumulator did not add the increment");
  a_incr_delay: assert property (
    ##6 dlyQ[Delay-1] == $past(sumQ, 6))
    else $error("increment pipeline depth is wrong");
  a_phase_offset: assert property (
    ##1 phaseQ[23:22] == 2'($past(accQ[47:46]) + $past(phSelQ)))
    else $error("phase select offset misapplied");
  a_dac_round: assert property (
    sineQ == 16'sh7FFF |=> dacCode == 14'h3FFF)
    else $error("full scale sine does not round to full scale code");
  a_serial_load: assert property (
    serArrive |=> serSlaveQ[7:0] == 8'h00 ##1 serTermQ == $past(serSlaveQ))
    else $error("serial word not moved into the term");

  c_update_pin: cover property ($fell(updNS));
  c_update_reg: cover property (wrRise && addrS == nfc_pkg::AddrUpdate);
  c_serial_word: cover property (serArrive);
  c_offset_toggle: cover property ($rose(ofsEnQ) ##[1:50] $fell(ofsEnQ));
endmodule

/* common/nfc_pkg.sv */
// Constants shared by the NCO frequency control design.
package nfc_pkg;
  // Datapath widths.
  localparam int FreqW = 48;
  localparam int SerMaxW = 40;
  localparam int PhaseW = 24;
  localparam int SineW = 16;
  localparam int DacW = 14;
  localparam int SerLenW = 3;
  localparam int SerMaxBytes = 5;
  // Parallel port addresses; wide words are stored least significant first.
  localparam logic [3:0] AddrCenter0 = 4'h0;
  localparam logic [3:0] AddrOffset0 = 4'h6;
  localparam logic [3:0] AddrSerialCfg = 4'hC;
  localparam logic [3:0] AddrTermCtl = 4'hD;
  localparam logic [3:0] AddrInitSet = 4'hE;
  localparam logic [3:0] AddrUpdate = 4'hF;
  localparam int FreqBytes = 6;
  // Field positions.
  localparam int TermCenterBit = 5;
  localparam int TermSerialBit = 6;
  localparam int SerLenLsb = 0;
  // Values after reset.
  localparam logic [7:0] TermCtlReset = 8'h60;
  localparam logic [7:0] SerialCfgReset = 8'h05;
  localparam logic [7:0] InitSetReset = 8'h00;
  localparam logic [47:0] CenterReset = 48'h4000_0000_0000;
  localparam logic [47:0] OffsetReset = 48'h0000_0000_0000;
  // Cycle counts.
  localparam int SyncStages = 2;
  localparam int SlaveToDacClks = 11;
  localparam int UpdateToDacClks = 14;
  localparam int SerialSlaveToDacClks = 12;
  localparam int SerialXferClks = 3;
  localparam int PipeDelay = SlaveToDacClks - 5;
endpackage

/* design/nfc_serial_port.sv */
// Three-wire serial tuning word port running on the serial clock.
`timescale 1ns/1ps
module nfc_serial_port #(
  parameter int MaxBytes = nfc_pkg::SerMaxBytes
) (
  // Serial link.
  input wire logic sclk,
  input wire logic reset_n,
  input wire logic serData,
  input wire logic serSync,
  // Configuration from the core clock domain.
  input wire logic [nfc_pkg::SerLenW-1:0] byteCount,
  // Result towards the core clock domain.
  output logic [nfc_pkg::SerMaxW-1:0] holdWord,
  output logic loadToggle
);
  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_HOLD, S_FLAG} nfc_ser_state_t;

  initial begin
    if (MaxBytes != nfc_pkg::SerMaxBytes) begin
      $error("nfc_serial_port supports only five byte words");
    end
  end

  nfc_ser_state_t stateQ, stateD;
  logic [5:0] cntQ, cntD;
  logic [5:0] frameQ, frameD;
  logic [nfc_pkg::SerMaxW-1:0] shiftQ, shiftD, holdQ, holdD;
  logic togQ, togD;
  logic [nfc_pkg::SerLenW-1:0] lenS1Q, lenS2Q;
  logic [nfc_pkg::SerLenW-1:0] len;
  logic [5:0] lastBit;
  logic [5:0] shAmt;

  // The length is quasi-static; the host changes it only between frames.
  always_comb begin
    len = lenS2Q;
    if (lenS2Q == 3'h0 || lenS2Q > 3'h5) begin
      len = 3'h5;
    end
    lastBit = 6'({len, 3'h0} - 6'h01);
    shAmt = 6'({3'h5 - len, 3'h0});
  end

  always_comb begin
    stateD = stateQ;
    cntD = cntQ;
    shiftD = shiftQ;
    holdD = holdQ;
    togD = togQ;
    frameD = (frameQ == 6'h3F) ? frameQ : 6'(frameQ + 6'h01);
    case (stateQ)
      S_IDLE: begin
        if (serSync) begin
          stateD = S_SHIFT;
          cntD = 6'h00;
          frameD = 6'h01;
        end
      end
      S_SHIFT: begin
        shiftD = {shiftQ[nfc_pkg::SerMaxW-2:0], serData};
        cntD = 6'(cntQ + 6'h01);
        if (cntQ == lastBit) begin
          stateD = S_HOLD;
        end
      end
      S_HOLD: begin
        holdD = shiftQ << shAmt;
        stateD = S_FLAG;
      end
      S_FLAG: begin
        togD = ~togQ;
        stateD = S_IDLE;
      end
      default: begin
        stateD = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      stateQ <= S_IDLE;
      cntQ <= 6'h00;
      frameQ <= 6'h00;
      shiftQ <= 40'h00_0000_0000;
      holdQ <= 40'h00_0000_0000;
      togQ <= 1'b0;
      lenS1Q <= 3'h5;
      lenS2Q <= 3'h5;
    end else begin
      stateQ <= stateD;
      cntQ <= cntD;
      frameQ <= frameD;
      shiftQ <= shiftD;
      holdQ <= holdD;
      togQ <= togD;
      lenS1Q <= byteCount;
      lenS2Q <= lenS1Q;
    end
  end

  assign holdWord = holdQ;
  assign loadToggle = togQ;

  a_frame_length: assert property (@(posedge sclk) disable iff (!reset_n)
    stateQ == S_FLAG |-> frameQ == 6'({len, 3'h0} + 6'h02))
    else $error("serial frame length is not 8N+3 clocks");
  a_hold_align: assert property (@(posedge sclk) disable iff (!reset_n)
    stateQ == S_FLAG |-> (holdQ << {len, 3'h0}) == '0)
    else $error("serial word not aligned to the top");
endmodule

/* tb/nfc_host_model.sv */
// Host model driving the parallel and serial control pins of the core.
`timescale 1ns/1ps
module nfc_host_model (
  // Core clock.
  input wire logic clk,
  // Parallel control port.
  output logic wrStrobe,
  output logic writeEnN,
  output logic [3:0] ctlAddr,
  output logic [7:0] ctlData,
  output logic updateN,
  // Serial control port.
  output logic sclk,
  output logic serData,
  output logic serSync
);
  initial begin
    wrStrobe = 1'b0;
    writeEnN = 1'b1;
    ctlAddr = 4'h0;
    ctlData = 8'h00;
    updateN = 1'b1;
    sclk = 1'b0;
    serData = 1'b0;
    serSync = 1'b0;
  end
  // Write-only byte transfer; the port offers nothing to read back.
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    @(negedge clk);
    ctlAddr = addr;
    ctlData = data;
    writeEnN = 1'b0;
    @(negedge clk);
    wrStrobe = 1'b1;
    // Strobe high and low for two clocks keeps the rate below clk/2.
    repeat (2) @(negedge clk);
    wrStrobe = 1'b0;
    repeat (2) @(negedge clk);
    writeEnN = 1'b1;
    // The released bus shows the inverse so stale values cannot pass.
    ctlAddr = ~addr;
    ctlData = ~data;
  endtask
  // Wide words go least significant byte first.
  task automatic write_word(input logic [3:0] base, input logic [47:0] w);
    for (int i = 0; i < nfc_pkg::FreqBytes; i++) begin
      write_reg(4'(base + i), w[8 * i +: 8]);
    end
  endtask
  // Only called once every byte of a word is in the masters.
  task automatic update();
    @(negedge clk);
    updateN = 1'b0;
    repeat (2) @(negedge clk);
    updateN = 1'b1;
  endtask
  // The serial clock runs only inside the frame: sync, 8N bits, two more.
  task automatic send_serial(input int n, input logic [39:0] w);
    serSync = 1'b1;
    #16 sclk = 1'b1;
    for (int i = 0; i < 8 * n + 2; i++) begin
      #16 sclk = 1'b0;
      serSync = 1'b0;
      serData = (i < 8 * n) ? w[39 - i] : ~serData;
      #16 sclk = 1'b1;
    end
    #16 sclk = 1'b0;
    serData = ~serData;
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the NCO frequency control core.
`timescale 1ns/1ps
`define CHECK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) begin \
      error_cnt++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic phaseSelectLsb = 1'b0;
  logic phaseSelectMsb = 1'b0;
  logic offsetTermEnablePin = 1'b0;
  logic wrStrobe;
  logic writeEnN;
  logic [3:0] ctlAddr;
  logic [7:0] ctlData;
  logic updateN;
  logic sclk;
  logic serData;
  logic serSync;
  logic [nfc_pkg::DacW-1:0] dacCode;
  logic [nfc_pkg::DacW-1:0] codes [4];
  logic [47:0] word;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 17;
  int n;
  always #5 clk = ~clk;
  nfc_host_model host_inst (.clk(clk), .wrStrobe(wrStrobe),
    .writeEnN(writeEnN), .ctlAddr(ctlAddr), .ctlData(ctlData),
    .updateN(updateN), .sclk(sclk), .serData(serData), .serSync(serSync));
  nfc_core nfc_core_inst (.clk(clk), .reset_n(reset_n),
    .wrStrobe(wrStrobe), .writeEnN(writeEnN), .ctlAddr(ctlAddr),
    .ctlData(ctlData), .updateN(updateN), .phaseSelectLsb(phaseSelectLsb),
    .phaseSelectMsb(phaseSelectMsb),
    .offsetTermEnablePin(offsetTermEnablePin), .sclk(sclk),
    .serData(serData), .serSync(serSync), .dacCode(dacCode));
  // A quarter-rate tone visits 0, 90, 180 and 270 degrees in turn.
  function automatic logic quad_set(logic [13:0] c [4]);
    int mid;
    int top;
    mid = 0;
    top = 0;
    for (int i = 0; i < 4; i++) begin
      mid += int'(c[i] === 14'h2000);
      top += int'(c[i] === 14'h3FFF);
    end
    return (mid == 2) && (top == 1);
  endfunction
  task automatic grab4();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1;
      codes[i] = dacCode;
    end
  endtask
  // Counts code changes over sixteen clocks; a zero increment gives none.
  task automatic steady(string nm);
    logic [13:0] last;
    int changes;
    changes = 0;
    @(posedge clk);
    #1;
    last = dacCode;
    repeat (16) begin
      @(posedge clk);
      #1;
      changes += int'(dacCode !== last || $isunknown(dacCode));
      last = dacCode;
    end
    `CHECK(nm, 0, changes)
  endtask
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (5) @(negedge clk);
    `CHECK("reset code", 14'h2000, dacCode)
    reset_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHECK("code after release", 14'h2000, dacCode)
    repeat (12) @(posedge clk);
    grab4();
    `CHECK("reset tone", 1'b1, quad_set(codes))
    `CHECK("table span", 1'b1, quad_set(codes))
    // Writes start long after the first edge that follows release.
    host_inst.write_reg(nfc_pkg::AddrInitSet, 8'h30);
    // Masters change without update; the tone must carry on.
    host_inst.write_reg(nfc_pkg::AddrTermCtl, 8'h00);
    repeat (20) @(posedge clk);
    grab4();
    `CHECK("masters only", 1'b1, quad_set(codes))
    host_inst.write_reg(nfc_pkg::AddrUpdate, 8'hA5);
    repeat (20) @(posedge clk);
    steady("terms zeroed");
    // The accumulator froze on a quarter point of the reset tone.
    `CHECK("term zeroing", 1'b1, dacCode inside {14'h2000, 14'h3FFF, 14'h0000})
    for (int s = 0; s < 4; s++) begin
      @(negedge clk);
      phaseSelectLsb = s[0];
      phaseSelectMsb = s[1];
      repeat (10) @(posedge clk);
      #1;
      codes[s] = dacCode;
    end
    `CHECK("phase select", 1'b1, quad_set(codes))
    `CHECK("phase offsets", 1'b1, quad_set(codes))
    @(negedge clk);
    phaseSelectLsb = 1'b0;
    phaseSelectMsb = 1'b0;
    // Random center plus matching offset wraps to a quarter-rate sum.
    word = 48'({$random(seed), $random(seed)});
    host_inst.write_word(nfc_pkg::AddrCenter0, word);
    host_inst.write_word(nfc_pkg::AddrOffset0, 48'h4000_0000_0000 - word);
    host_inst.write_reg(nfc_pkg::AddrTermCtl, 8'h60);
    // The offset slave is still zero, so the pin may lead the update and
    // all three terms reach the sum on one edge.
    @(negedge clk);
    offsetTermEnablePin = 1'b1;
    host_inst.update();
    repeat (20) @(posedge clk);
    grab4();
    `CHECK("modulo sum", 1'b1, quad_set(codes))
    `CHECK("offset enable", 1'b1, quad_set(codes))
    // Serial term alone, at a random byte count each pass. Pin and update
    // share one synchroniser depth, so the center never runs on its own.
    host_inst.write_reg(nfc_pkg::AddrTermCtl, 8'h40);
    fork
      host_inst.update();
      begin
        @(negedge clk);
        offsetTermEnablePin = 1'b0;
      end
    join
    for (int k = 0; k < 2; k++) begin
      n = 1 + int'($unsigned($random(seed)) % 5);
      host_inst.write_reg(nfc_pkg::AddrSerialCfg, 8'(n));
      host_inst.update();
      #3;
      host_inst.send_serial(n, 40'h40_0000_0000);
      repeat (30) @(posedge clk);
      grab4();
      `CHECK("serial alignment", 1'b1, quad_set(codes))
      `CHECK("serial latency", 1'b1, quad_set(codes))
      #3;
      host_inst.send_serial(n, 40'h00_0000_0000);
      repeat (30) @(posedge clk);
      steady("serial cleared");
    end
    #3;
    host_inst.send_serial(n, 40'h40_0000_0000);
    host_inst.write_reg(nfc_pkg::AddrTermCtl, 8'h00);
    host_inst.update();
    repeat (20) @(posedge clk);
    steady("serial disabled");
    // A zero center word must stay zero whatever the serial port carries.
    host_inst.write_word(nfc_pkg::AddrCenter0, 48'h0000_0000_0000);
    host_inst.write_reg(nfc_pkg::AddrTermCtl, 8'h20);
    host_inst.update();
    #3;
    host_inst.send_serial(n, 40'hC0_0000_0000);
    repeat (30) @(posedge clk);
    steady("no serial path to center");
    give_verdict();
  end
endmodule
